//--- verilog/manchester_link_pkg.sv
// Constants, types and CRC helpers shared by the Manchester command link
package manchester_link_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 10;

  // Frame layout, bit indices counted from the first sync bit
  localparam logic [5:0] DIR_POS          = 6'h02;
  localparam logic [5:0] CRC_BITS         = 6'h03;
  localparam logic [5:0] READ_FRAME_BITS  = 6'h10;
  localparam logic [5:0] WRITE_FRAME_BITS = 6'h20;
  localparam logic [2:0] CRC_PRESET       = 3'h7;

  // Special codes
  localparam logic [5:0]  SPECIAL_ADDR = 6'h3F;
  localparam logic [15:0] ACCESS_CODE  = 16'h62D2;
  localparam logic [15:0] EXIT_CODE    = 16'h0000;

  // Reply frame: status (6) + data (16) + CRC (3)
  localparam logic [4:0] REPLY_LAST = 5'h18;

  // Timing in nanoseconds and derived cycle counts
  localparam int TIMER_W            = 20;
  localparam int BIT_TIME_NS        = 8000;
  localparam int GATE_TIME_NS       = 1000;
  localparam int TURNAROUND_NS      = 20000;
  localparam int PREAMBLE_NS        = 10000;
  localparam int AUX_HOLD_NS        = 90000;
  localparam int ACCESS_TIMEOUT_NS  = 300000;
  localparam logic [TIMER_W-1:0] BIT_CYC      = TIMER_W'(BIT_TIME_NS / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] HALF_CYC     = TIMER_W'(BIT_TIME_NS / CLK_PERIOD_NS / 2);
  localparam logic [TIMER_W-1:0] MID_MIN_CYC  = TIMER_W'(BIT_TIME_NS * 3 / 4 / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] EDGE_MAX_CYC = TIMER_W'(BIT_TIME_NS * 3 / 2 / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] GATE_CYC     = TIMER_W'((GATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] TD_CYC       = TIMER_W'((TURNAROUND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] TB_CYC       = TIMER_W'((PREAMBLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Operating modes; code 2'b11 is illegal
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_ENTRY  = 2'b01,
    MODE_ACTIVE = 2'b10
  } mode_type;

  typedef enum logic {
    DEC_IDLE = 1'b0,
    DEC_BITS = 1'b1
  } dec_type;

  typedef enum logic [1:0] {
    RPL_IDLE = 2'b00,
    RPL_TURN = 2'b01,
    RPL_PRE  = 2'b10,
    RPL_BITS = 2'b11
  } rpl_type;

  // Command handed to the register side
  typedef struct packed {
    logic        valid;
    logic        read;
    logic [5:0]  addr;
    logic [15:0] data;
  } cmd_type;

  // Return-status field, sent first in every reply
  typedef struct packed {
    logic [1:0] id;
    logic       broadcast;
    logic       abort;
    logic       overrun;
    logic       checksum;
  } status_type;

  // One step of the x^3 + x + 1 register, data fed MSB first
  function automatic logic [2:0] crc3_step(input logic [2:0] crc, input logic din);
    logic fb;
    fb = din ^ crc[2];
    return {crc[1], crc[0] ^ fb, fb};
  endfunction

  // CRC over a whole reply body, MSB first
  function automatic logic [2:0] crc3_word(input logic [21:0] word);
    logic [2:0] crc;
    crc = CRC_PRESET;
    for (int i = 21; i >= 0; i--) begin
      crc = crc3_step(crc, word[i]);
    end
    return crc;
  endfunction

endpackage

//--- verilog/pin_sync_filter.sv
// Three-stage pin synchroniser whose output moves only when stages two and three agree
`timescale 1ns/1ps
module pin_sync_filter #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  // Pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } filt_state_type;

  filt_state_type s_q;
  filt_state_type s_d;

  // Stage one feeds only stage two; the agreement test looks at two and three
  always_comb begin
    s_d       = s_q;
    s_d.s1    = pin_i;
    s_d.s2    = s_q.s1;
    s_d.s3    = s_q.s2;
    s_d.level = (s_q.s2 & s_q.s3) | (s_q.level & (s_q.s2 | s_q.s3));
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.level;

endmodule

//--- verilog/manchester_command_link.sv
// Manchester command link sharing the sensor output line: decode, entry, access, reply
`timescale 1ns/1ps
module manchester_command_link
  import manchester_link_pkg::*;
#(
  parameter logic [TIMER_W-1:0] AUX_HOLD_CYC       = TIMER_W'((AUX_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS),
  parameter logic [TIMER_W-1:0] ACCESS_TIMEOUT_CYC = TIMER_W'(ACCESS_TIMEOUT_NS / CLK_PERIOD_NS)
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // Shared output line, open drain
  input  wire logic        shared_output_pin_i,
  output logic             shared_output_pin_o,
  output logic             shared_output_pin_oe_o,
  // Straps and configuration
  input  wire logic        die_strap_low_i,
  input  wire logic        die_strap_high_i,
  input  wire logic        interface_select_pin_i,
  input  wire logic        short_sent_variant_i,
  input  wire logic        advanced_sent_variant_i,
  input  wire logic        serial_disable_bit_i,
  // Angle output core
  input  wire logic        angle_out_i,
  input  wire logic        fault_flag_i,
  // Register side
  output cmd_type          cmd_o,
  input  wire logic [15:0] rd_data_i,
  // Mode status
  output logic             serial_mode_o,
  output logic             serial_active_o
);

  typedef struct packed {
    mode_type           mode;
    dec_type            dec;
    rpl_type            rpl;
    logic               line_prev;
    logic [TIMER_W-1:0] low_cnt;
    logic [TIMER_W-1:0] hold_cnt;
    logic [TIMER_W-1:0] entry_cnt;
    logic               entry_seen;
    logic [TIMER_W-1:0] bit_tmr;
    logic [5:0]         bit_cnt;
    logic [5:0]         frame_len;
    logic [29:0]        shreg;
    logic [2:0]         crc;
    logic [TIMER_W-1:0] rpl_tmr;
    logic [4:0]         rpl_idx;
    logic               rpl_half;
    logic [24:0]        rpl_sh;
    logic               bcast;
    logic               abort_flag;
    logic               overrun_flag;
    logic               checksum_flag;
    logic               line_oe;
    logic               line_out;
    cmd_type            cmd;
    logic               ser_mode;
    logic               ser_active;
  } link_state_type;

  link_state_type s_q;
  link_state_type s_d;

  logic [3:0]  pin_lvl;
  logic        line_lvl;
  logic        interface_select_pin_lvl;
  logic [1:0]  identity;
  status_type  status_now;
  logic        rise;
  logic        fall;
  logic        own_drive;
  logic        dec_enable;
  logic        frame_done;
  logic        abort_set;
  logic        overrun_set;
  logic        checksum_set;
  logic [5:0]  len_now;
  logic        fr_read;
  logic [3:0]  fr_mask;
  logic [5:0]  fr_addr;
  logic [15:0] fr_data;
  logic        selected;

  // Line, select pin and straps all come from outside the clock domain
  pin_sync_filter #(
    .WIDTH (4)
  ) u_pins (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     ({shared_output_pin_i, interface_select_pin_i, die_strap_high_i, die_strap_low_i}),
    .level_o   (pin_lvl)
  );

  assign line_lvl = pin_lvl[3];
  assign interface_select_pin_lvl = pin_lvl[2];
  assign identity = pin_lvl[1:0];

  // Status sent with each reply; broadcast replaces the identity by zero
  assign status_now = '{id:        s_q.bcast ? 2'h0 : identity,
                        broadcast: s_q.bcast,
                        abort:     s_q.abort_flag,
                        overrun:   s_q.overrun_flag,
                        checksum:  s_q.checksum_flag};

  // Next-state logic for the whole link
  always_comb begin
    s_d           = s_q;
    rise          = line_lvl & ~s_q.line_prev;
    fall          = ~line_lvl & s_q.line_prev;
    own_drive     = (s_q.rpl == RPL_PRE) || (s_q.rpl == RPL_BITS);
    dec_enable    = (s_q.mode != MODE_NORMAL) && !serial_disable_bit_i && !own_drive;
    frame_done    = 1'b0;
    abort_set     = 1'b0;
    overrun_set   = 1'b0;
    checksum_set  = 1'b0;
    len_now       = s_q.frame_len;
    fr_read       = 1'b0;
    fr_mask       = 4'h0;
    fr_addr       = 6'h00;
    fr_data       = 16'h0000;
    selected      = 1'b0;
    s_d.cmd.valid = 1'b0;
    s_d.line_prev = line_lvl;

    // Low-time tracker; own drive never counts, so our release edge cannot look like a start
    if (line_lvl || own_drive) begin
      s_d.low_cnt = '0;
    end else if (s_q.low_cnt != GATE_CYC) begin
      s_d.low_cnt = s_q.low_cnt + 1'b1;
    end

    // Reply sequencer: turnaround, low preamble, then Manchester bits
    unique case (s_q.rpl)
      RPL_IDLE: begin
        s_d.rpl_tmr = '0;
      end
      RPL_TURN: begin
        s_d.rpl_tmr = s_q.rpl_tmr + 1'b1;
        if (s_q.rpl_tmr == TD_CYC - 1'b1) begin
          s_d.rpl     = RPL_PRE;
          s_d.rpl_tmr = '0;
        end
      end
      RPL_PRE: begin
        s_d.rpl_tmr = s_q.rpl_tmr + 1'b1;
        if (s_q.rpl_tmr == TB_CYC - 1'b1) begin
          s_d.rpl_sh        = {status_now, rd_data_i, crc3_word({status_now, rd_data_i})};
          s_d.rpl           = RPL_BITS;
          s_d.rpl_tmr       = '0;
          s_d.rpl_idx       = 5'h00;
          s_d.rpl_half      = 1'b0;
          // Reported flags are cleared; a set later in this cycle still wins
          s_d.abort_flag    = 1'b0;
          s_d.overrun_flag  = 1'b0;
          s_d.checksum_flag = 1'b0;
        end
      end
      RPL_BITS: begin
        s_d.rpl_tmr = s_q.rpl_tmr + 1'b1;
        if (s_q.rpl_tmr == HALF_CYC - 1'b1) begin
          s_d.rpl_tmr = '0;
          if (!s_q.rpl_half) begin
            s_d.rpl_half = 1'b1;
          end else begin
            s_d.rpl_half = 1'b0;
            s_d.rpl_sh   = {s_q.rpl_sh[23:0], 1'b0};
            s_d.rpl_idx  = s_q.rpl_idx + 1'b1;
            if (s_q.rpl_idx == REPLY_LAST) begin
              s_d.rpl = RPL_IDLE;
            end
          end
        end
      end
    endcase

    // Mode control: auxiliary-pulse entry and access timeout
    unique case (s_q.mode)
      MODE_NORMAL: begin
        // Count low time only while the angle output itself releases the line
        if (line_lvl) begin
          s_d.hold_cnt = '0;
        end else if (angle_out_i && s_q.hold_cnt != AUX_HOLD_CYC) begin
          s_d.hold_cnt = s_q.hold_cnt + 1'b1;
        end
        if (rise && s_q.hold_cnt == AUX_HOLD_CYC && !serial_disable_bit_i &&
            (short_sent_variant_i || advanced_sent_variant_i)) begin
          s_d.mode       = MODE_ENTRY;
          s_d.entry_cnt  = '0;
          s_d.entry_seen = 1'b0;
          s_d.hold_cnt   = '0;
        end
      end
      MODE_ENTRY: begin
        if (!s_q.entry_seen) begin
          s_d.entry_cnt = s_q.entry_cnt + 1'b1;
          if (s_q.entry_cnt == ACCESS_TIMEOUT_CYC) begin
            s_d.mode = MODE_NORMAL;
            s_d.dec  = DEC_IDLE;
          end
        end
      end
      MODE_ACTIVE: begin
        s_d.hold_cnt = '0;
      end
      default: begin
        s_d.mode = MODE_NORMAL;
      end
    endcase

    // Frame decoder: only mid-cell edges carry data, boundary edges come too early
    if (!dec_enable) begin
      s_d.dec = DEC_IDLE;
    end else begin
      unique case (s_q.dec)
        DEC_IDLE: begin
          // The rising mid-cell edge of the first sync bit, after a gate-long low, opens a frame
          if (rise && s_q.low_cnt == GATE_CYC) begin
            s_d.dec        = DEC_BITS;
            s_d.bit_cnt    = 6'h01;
            s_d.bit_tmr    = '0;
            s_d.shreg      = '0;
            s_d.crc        = CRC_PRESET;
            s_d.frame_len  = WRITE_FRAME_BITS;
            s_d.entry_seen = 1'b1;
            if (s_q.rpl == RPL_TURN) begin
              overrun_set = 1'b1;
              s_d.rpl     = RPL_IDLE;
            end
          end
        end
        DEC_BITS: begin
          s_d.bit_tmr = s_q.bit_tmr + 1'b1;
          if ((rise || fall) && s_q.bit_tmr >= MID_MIN_CYC) begin
            s_d.bit_tmr = '0;
            if (s_q.bit_cnt == DIR_POS - 1'b1 && fall) begin
              s_d.dec = DEC_IDLE;
            end else begin
              if (s_q.bit_cnt == DIR_POS) begin
                len_now = fall ? READ_FRAME_BITS : WRITE_FRAME_BITS;
              end
              s_d.frame_len = len_now;
              s_d.shreg     = {s_q.shreg[28:0], fall};
              if (s_q.bit_cnt >= DIR_POS && s_q.bit_cnt + CRC_BITS < len_now) begin
                s_d.crc = crc3_step(s_q.crc, fall);
              end
              s_d.bit_cnt = s_q.bit_cnt + 1'b1;
              if (s_q.bit_cnt + 1'b1 == len_now) begin
                frame_done = 1'b1;
                s_d.dec    = DEC_IDLE;
                s_d.low_cnt = GATE_CYC - MID_MIN_CYC;  // Host release after a low last half is no frame start
              end
            end
          end else if (s_q.bit_tmr >= EDGE_MAX_CYC) begin
            s_d.dec = DEC_IDLE;
            if (s_q.bit_cnt >= DIR_POS) begin
              abort_set = 1'b1;
            end
          end
        end
      endcase
    end

    // Completed frame: field split, CRC check, selection and action
    if (frame_done) begin
      fr_read = (s_d.frame_len == READ_FRAME_BITS);
      if (fr_read) begin
        {fr_mask, fr_addr} = s_d.shreg[12:3];
      end else begin
        {fr_mask, fr_addr, fr_data} = s_d.shreg[28:3];
      end
      selected = (fr_mask == 4'h0) || interface_select_pin_lvl || fr_mask[identity];
      if (s_d.shreg[2:0] != s_d.crc) begin
        checksum_set = 1'b1;
      end else if (selected) begin
        if (!fr_read && fr_addr == SPECIAL_ADDR && fr_data == ACCESS_CODE) begin
          s_d.mode = MODE_ACTIVE;
        end else if (!fr_read && fr_addr == SPECIAL_ADDR && fr_data == EXIT_CODE) begin
          s_d.mode = MODE_NORMAL;
          s_d.rpl  = RPL_IDLE;
        end else if (s_q.mode == MODE_ACTIVE) begin
          s_d.cmd.valid = 1'b1;
          s_d.cmd.read  = fr_read;
          s_d.cmd.addr  = fr_addr;
          s_d.cmd.data  = fr_data;
          if (fr_read) begin
            s_d.rpl     = RPL_TURN;
            s_d.rpl_tmr = '0;
            s_d.bcast   = (fr_mask == 4'h0);
          end
        end
      end
    end

    // Sticky error flags; a set wins over the clear at reply load
    if (abort_set) begin
      s_d.abort_flag = 1'b1;
    end
    if (overrun_set) begin
      s_d.overrun_flag = 1'b1;
    end
    if (checksum_set) begin
      s_d.checksum_flag = 1'b1;
    end

    // Line drive: live angle stream in normal mode unless fault_flag_i releases the line, reply otherwise, never a contention check
    if (s_d.mode == MODE_NORMAL) begin
      s_d.line_oe = ~angle_out_i & ~fault_flag_i;
    end else begin
      s_d.line_oe = (s_d.rpl == RPL_PRE) ||
                    ((s_d.rpl == RPL_BITS) && !(s_d.rpl_sh[24] ^ s_d.rpl_half));
    end
    s_d.line_out   = 1'b0;
    s_d.ser_mode   = (s_d.mode != MODE_NORMAL);
    s_d.ser_active = (s_d.mode == MODE_ACTIVE);
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign shared_output_pin_o    = s_q.line_out;
  assign shared_output_pin_oe_o = s_q.line_oe;
  assign cmd_o                  = s_q.cmd;
  assign serial_mode_o          = s_q.ser_mode;
  assign serial_active_o        = s_q.ser_active;

endmodule

//--- bench/link_sva.sv
// Port assertions for the Manchester command link
`timescale 1ns/1ps
module link_sva
  import manchester_link_pkg::*;
(
  // Clock and reset
  input wire logic    sys_clk_i,
  input wire logic    reset_n_i,
  // Line and configuration
  input wire logic    shared_output_pin_i,
  input wire logic    shared_output_pin_o,
  input wire logic    shared_output_pin_oe_o,
  input wire logic    short_sent_variant_i,
  input wire logic    advanced_sent_variant_i,
  input wire logic    serial_disable_bit_i,
  input wire logic    angle_out_i,
  input wire logic    fault_flag_i,
  // Command and mode
  input wire cmd_type cmd_o,
  input wire logic    serial_mode_o,
  input wire logic    serial_active_o
);
  localparam int TURN_END = 3100;
  logic [12:0] turn_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  // Cycles since a read was taken; a host rise during turnaround is an overrun and cancels
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      turn_q <= 13'h0000;
    end else if (cmd_o.valid && cmd_o.read) begin
      turn_q <= 13'h0001;
    end else if (($rose(shared_output_pin_i) && turn_q < TD_CYC) || turn_q >= TURN_END) begin
      turn_q <= 13'h0000;
    end else if (turn_q != 13'h0000) begin
      turn_q <= turn_q + 13'h0001;
    end
  end

  // Reply steps: command taken, then the preamble pull-down
  sequence s_read_cmd;
    cmd_o.valid && cmd_o.read;
  endsequence
  sequence s_preamble;
    turn_q >= TD_CYC && turn_q < TD_CYC + TB_CYC;
  endsequence

  property p_pin_low; shared_output_pin_o == 1'b0; endproperty
  property p_valid_pulse; cmd_o.valid |=> !cmd_o.valid; endproperty
  property p_read_active; s_read_cmd |-> serial_active_o; endproperty
  property p_turn_quiet; turn_q != 13'h0000 && turn_q < TD_CYC |-> !shared_output_pin_oe_o; endproperty
  property p_preamble; s_preamble |-> shared_output_pin_oe_o; endproperty
  property p_follow;
    !serial_mode_o && !$past(serial_mode_o) && $past(reset_n_i)
      |-> shared_output_pin_oe_o == $past(!angle_out_i && !fault_flag_i);
  endproperty
  property p_entry;
    $rose(serial_mode_o) |-> $past(short_sent_variant_i || advanced_sent_variant_i) && !$past(serial_disable_bit_i);
  endproperty
  property p_exit; $fell(serial_active_o) |-> !serial_mode_o; endproperty
  property p_disabled;
    serial_disable_bit_i && $past(serial_disable_bit_i) && $past(serial_disable_bit_i, 2) |-> !cmd_o.valid;
  endproperty
  property p_entry_quiet; serial_mode_o && !serial_active_o |-> !shared_output_pin_oe_o; endproperty

  a_pin_low: assert property (p_pin_low) else $error("line data output not low");
  a_valid_pulse: assert property (p_valid_pulse) else $error("command valid longer than one cycle");
  a_read_active: assert property (p_read_active) else $error("read taken before access");
  a_turn_quiet: assert property (p_turn_quiet) else $error("line driven during turnaround");
  a_preamble: assert property (p_preamble) else $error("line not low in preamble");
  a_follow: assert property (p_follow) else $error("normal output not following angle stream");
  a_entry: assert property (p_entry) else $error("serial mode entered without variant");
  a_exit: assert property (p_exit) else $error("exit left serial mode open");
  a_disabled: assert property (p_disabled) else $error("command passed while disabled");
  a_entry_quiet: assert property (p_entry_quiet) else $error("line driven before access");
  c_read: cover property (s_read_cmd);
endmodule

bind manchester_command_link link_sva chk_u (
  .sys_clk_i, .reset_n_i, .shared_output_pin_i, .shared_output_pin_o, .shared_output_pin_oe_o,
  .short_sent_variant_i, .advanced_sent_variant_i, .serial_disable_bit_i, .angle_out_i,
  .fault_flag_i, .cmd_o, .serial_mode_o, .serial_active_o
);

//--- bench/host_model.sv
// Host controller model on the shared open-drain line
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic sys_clk_i,
  // Shared line
  input  wire logic line_i,
  output logic      line_low_o
);
  initial line_low_o = 1'b0;

  // Whole cycles, then step just past the edge so changes never race it
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // Long low pulse, then float long enough for the rise to be seen
  task automatic aux_pulse();
    line_low_o = 1'b1;
    hold(100);
    line_low_o = 1'b0;
    hold(150);
  endtask

  // Gate low, then the whole frame with its CRC, 400 cycles a half cell
  task automatic send_cmd(input logic rd, input logic [3:0] mask, input logic [5:0] addr, input logic [15:0] data);
    logic [31:0] f;
    logic [2:0]  c;
    logic        fb;
    int          n;
    n = rd ? 16 : 32;
    f = rd ? {16'h0000, 2'h0, rd, mask, addr, 3'h0} : {2'h0, rd, mask, addr, data, 3'h0};
    c = 3'h7;
    for (int i = n - 3; i >= 3; i--) begin
      fb = f[i] ^ c[2];
      c = {c[1], c[0] ^ fb, fb};
    end
    f[2:0] = c;
    line_low_o = 1'b1;
    hold(200);
    for (int i = n - 1; i >= 0; i--) begin
      line_low_o = !f[i];
      hold(400);
      line_low_o = f[i];
      hold(400);
    end
    // Released for a full cycle, so a following frame never re-drives in the same step
    line_low_o = 1'b0;
    hold(1);
  endtask

  // Wait for the pull-down, then sample mid first half of every reply cell
  task automatic recv_reply(output logic [24:0] bits, output logic ok);
    int w;
    w = 0;
    while (line_i && w < 3000) begin
      hold(1);
      w++;
    end
    ok = !line_i;
    hold(1200);
    for (int i = 24; i >= 0; i--) begin
      bits[i] = line_i;
      hold(800);
    end
  endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench for the Manchester command link
`timescale 1ns/1ps
module testbench
  import manchester_link_pkg::*;
;
  logic        sys_clk_i;
  logic        reset_n_i;
  logic        shared_output_pin_i;
  logic        shared_output_pin_o;
  logic        shared_output_pin_oe_o;
  logic        die_strap_low_i;
  logic        die_strap_high_i;
  logic        interface_select_pin_i;
  logic        short_sent_variant_i;
  logic        advanced_sent_variant_i;
  logic        serial_disable_bit_i;
  logic        angle_out_i;
  logic        fault_flag_i;
  cmd_type     cmd_o;
  logic [15:0] rd_data_i;
  logic        serial_mode_o;
  logic        serial_active_o;
  logic        host_low;
  logic [24:0] bits;
  logic        ok;
  int          failures;
  int          checks_done;

  // Pull-up wins unless someone pulls low
  assign shared_output_pin_i = !(host_low || shared_output_pin_oe_o);

  manchester_command_link #(.AUX_HOLD_CYC(20'h00032), .ACCESS_TIMEOUT_CYC(20'h00BB8)) dut_u (
    .sys_clk_i, .reset_n_i, .shared_output_pin_i, .shared_output_pin_o, .shared_output_pin_oe_o,
    .die_strap_low_i, .die_strap_high_i, .interface_select_pin_i, .short_sent_variant_i,
    .advanced_sent_variant_i, .serial_disable_bit_i, .angle_out_i, .fault_flag_i, .cmd_o,
    .rd_data_i, .serial_mode_o, .serial_active_o
  );
  host_model host_u (.sys_clk_i, .line_i(shared_output_pin_i), .line_low_o(host_low));

  // Clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic check(input string what, input logic [24:0] exp, input logic [24:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Own CRC of the reply body, kept apart from the design's helpers
  function automatic logic [2:0] crc_of(input logic [21:0] w);
    logic [2:0] c;
    logic       fb;
    c = 3'h7;
    for (int i = 21; i >= 0; i--) begin
      fb = w[i] ^ c[2];
      c = {c[1], c[0] ^ fb, fb};
    end
    return c;
  endfunction

  // Disabled interface must not even enter
  task automatic t_disabled();
    serial_disable_bit_i = 1'b1;
    host_u.aux_pulse();
    check("mode while disabled", 25'h0, serial_mode_o);
    serial_disable_bit_i = 1'b0;
    wait_cyc(200);
  endtask

  // Entry with no access code falls back to normal output
  task automatic t_timeout();
    short_sent_variant_i = 1'b0;
    advanced_sent_variant_i = 1'b1;
    host_u.aux_pulse();
    check("mode after pulse", 25'h1, serial_mode_o);
    wait_cyc(3000);
    check("mode after timeout", 25'h0, serial_mode_o);
    short_sent_variant_i = 1'b1;
    advanced_sent_variant_i = 1'b0;
  endtask

  // Broadcast access code opens the full command set
  task automatic t_access();
    host_u.aux_pulse();
    host_u.send_cmd(1'b0, 4'h0, 6'h3F, 16'h62D2);
    check("mode after access", 25'h3, {serial_mode_o, serial_active_o});
  endtask

  // Selected read: turnaround, preamble, status, data and CRC on the wire
  task automatic t_read();
    logic [21:0] body;
    host_u.send_cmd(1'b1, 4'h4, 6'h15, 16'h0000);
    check("read command", {1'b1, 6'h15, 16'h0000}, {cmd_o.read, cmd_o.addr, cmd_o.data});
    host_u.recv_reply(bits, ok);
    check("reply pull-down", 25'h1, ok);
    body = {2'h2, 4'h0, 16'hA5C3};
    check("reply frame", {body, crc_of(body)}, bits);
  endtask

  // Exit through the select pin's broadcast, mask naming another die; fault releases the line
  task automatic t_exit();
    interface_select_pin_i = 1'b1;
    host_u.send_cmd(1'b0, 4'h1, 6'h3F, 16'h0000);
    check("mode after exit", 25'h0, {serial_mode_o, serial_active_o});
    interface_select_pin_i = 1'b0;
    angle_out_i = 1'b0;
    wait_cyc(3);
    check("line with angle low", 25'h1, shared_output_pin_oe_o);
    fault_flag_i = 1'b1;
    wait_cyc(3);
    check("line with fault", 25'h0, shared_output_pin_oe_o);
    fault_flag_i = 1'b0;
    angle_out_i = 1'b1;
  endtask

  // Main sequence
  initial begin
    failures = 0;
    checks_done = 0;
    reset_n_i = 1'b0;
    die_strap_low_i = 1'b0;
    die_strap_high_i = 1'b1;
    interface_select_pin_i = 1'b0;
    short_sent_variant_i = 1'b1;
    advanced_sent_variant_i = 1'b0;
    serial_disable_bit_i = 1'b0;
    angle_out_i = 1'b1;
    fault_flag_i = 1'b0;
    rd_data_i = 16'hA5C3;
    wait_cyc(16);
    check("reset outputs", 25'h0, {shared_output_pin_oe_o, serial_mode_o, serial_active_o, cmd_o.valid});
    reset_n_i = 1'b1;
    wait_cyc(8);
    t_disabled();
    t_timeout();
    t_access();
    t_read();
    t_exit();
    stop_test();
  end

  // Watchdog past the expected run of about 92000 cycles, still under the run limit
  initial begin
    #990000;
    failures++;
    $display("unexpected watchdog: expected end of tests, seen timeout");
    stop_test();
  end
endmodule
